/* File: cfb_cfg.svh */
// Constants of the configuration fuse bank: offsets, masks, defaults.
// Assumes byte addresses as seen by table reads into configuration space.
`ifndef CFB_CFG_SVH
`define CFB_CFG_SVH

`define CFB_ADDR_W 24
`define CFB_OFS_OSC 24'h300001
`define CFB_OFS_BOR 24'h300002
`define CFB_OFS_WDT 24'h300003
`define CFB_OFS_PWM 24'h300004
`define CFB_OFS_MUX 24'h300005
`define CFB_OFS_DBG 24'h300006
`define CFB_OFS_CPL 24'h300008
`define CFB_OFS_CPH 24'h300009

// Unprogrammed values
`define CFB_DEF_OSC 8'h07
`define CFB_DEF_BOR 8'h1f
`define CFB_DEF_WDT 8'h1f
`define CFB_DEF_PWM 8'h0e
`define CFB_DEF_MUX 8'h81
`define CFB_DEF_DBG 8'h81
`define CFB_DEF_CPL 8'h03
`define CFB_DEF_CPH 8'hc0

// Implemented bits
`define CFB_MSK_OSC 8'hcf
`define CFB_MSK_BOR 8'h1f
`define CFB_MSK_WDT 8'h1f
`define CFB_MSK_PWM 8'h0e
`define CFB_MSK_MUX 8'h89
`define CFB_MSK_DBG 8'hf1
`define CFB_MSK_CPL 8'h03
`define CFB_MSK_CPH 8'hc0

// Field positions
`define CFB_B_SWITCHOVER 7
`define CFB_B_FAILSAFE 6
`define CFB_B_PWRT_N 0
`define CFB_B_WDT_EN 0
`define CFB_B_ODD_POL 3
`define CFB_B_EVEN_POL 2
`define CFB_B_PWM_RST 1
`define CFB_B_EXTERNAL_RESET_PIN_EN 7
`define CFB_B_T1_MUX 3
`define CFB_B_FLT_MUX 0
`define CFB_B_BKDBG 7
`define CFB_B_XISA 6
`define CFB_B_STK_RST 0
`define CFB_B_CP_DATA 7
`define CFB_B_CP_BOOT 6

// Boot block sizes in words
`define CFB_BB_256 11'd256
`define CFB_BB_512 11'd512
`define CFB_BB_1K 11'd1024
`define CFB_PWM_EN_ACTIVE 3'h4

// Watchdog base period
`define CFB_WDT_BASE_MS 4
`define CFB_CLK_PERIOD_NS 25

`endif

/* File: cfb_pkg.sv */
// Types shared by the configuration fuse bank.
// Assumes the constants header is included where offsets are needed.
package cfb_pkg;

   typedef enum logic [2:0] {
      OSC_LOW_POWER_CRYSTAL,
      OSC_STANDARD_CRYSTAL,
      OSC_HIGH_SPEED_CRYSTAL,
      OSC_HIGH_SPEED_PLL,
      OSC_EXTERNAL_CLOCK_INPUT,
      OSC_EXTERNAL_RC,
      OSC_INTERNAL_BLOCK
   } cfb_osc_src_t;

   typedef struct packed {
      logic [23:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } cfb_bus_t;

   typedef struct packed {
      cfb_osc_src_t src;
      logic clock_out_pin;
      logic port_a_bit6_io;
      logic port_a_bit7_io;
      logic pll;
   } cfb_osc_dec_t;

endpackage

/* File: cfb_top.sv */
// Configuration fuse bank: nonvolatile option bytes and their decode.
// Assumes POR_I marks power-on (storage start-up), RST_I device reset,
// and that the bus master follows the one-cycle strobe protocol.
// Behaviour
// - Code 1001/1000 selects internal oscillator block
// - Code 0110 is high-speed crystal, PLL x4
// - Codes 11xx,101x,0011,0111 select external RC
// - 0101/0100 external clock; 0010..0000 crystals
// - Switchover mode enable bit
// - Fail-safe clock monitor enable bit
// - Brown-out mode: hardware, sleep-off, software, off
// - Brown-out level field, 11 lowest
// - Power-up timer active low, independent
// - Watchdog ratio is two to postscale
// - Watchdog forced on or software controlled
// - Odd and even PWM polarity bits
// - Polarity applies to normal, fault, override
// - PWM reset state and enable field
// - Master clear versus port A bit 5
// - Timer1 pin and fault A pin mux
// - Background debug disable frees port B pins
// - Extended instruction set enable
// - Boot block size by part
// - Reset on stack overflow or underflow
// - Code block protect, clear only outside program mode
// - Data and boot protect, clear only outside program mode
// - Watchdog base period four milliseconds
`timescale 1ns/1ps
`include "cfb_cfg.svh"

module cfb_top #(
   parameter bit LARGE_PART = 1'b1,
   parameter int WDT_BASE_CYC =
      `CFB_WDT_BASE_MS * 1000000 / `CFB_CLK_PERIOD_NS
) (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic POR_I,
   input wire logic CE_I,
   input wire cfb_pkg::cfb_bus_t BUS_I,
   input wire logic PROG_MODE_I,
   input wire logic SLEEP_I,
   input wire logic SOFT_BROWNOUT_EN_I,
   input wire logic WATCHDOG_SOFT_EN_I,
   input wire logic [5:0] PWM_LOGIC_I,
   output logic [7:0] RD_DATA_O,
   output cfb_pkg::cfb_osc_src_t OSC_SOURCE_O,
   output logic CLOCK_OUT_PIN_O,
   output logic PORT_A_BIT6_IO_O,
   output logic PORT_A_BIT7_IO_O,
   output logic PLL_EN_O,
   output logic OSC_SWITCHOVER_EN_O,
   output logic FAILSAFE_MONITOR_EN_O,
   output logic BROWNOUT_ACTIVE_O,
   output logic [1:0] BROWNOUT_LEVEL_O,
   output logic POWERUP_TIMER_EN_O,
   output logic WATCHDOG_RUN_O,
   output logic [15:0] WATCHDOG_RATIO_O,
   output logic [31:0] WATCHDOG_BASE_CYC_O,
   output logic ODD_PWM_POLARITY_O,
   output logic EVEN_PWM_POLARITY_O,
   output logic PWM_OFF_AT_RESET_O,
   output logic [2:0] PWM_OUTPUT_ENABLES_O,
   output logic [5:0] PWM_PIN_O,
   output logic EXTERNAL_RESET_EN_O,
   output logic PORT_A_BIT5_IN_EN_O,
   output logic TIMER1_PIN_ON_A6_O,
   output logic FAULT_A_ON_A5_O,
   output logic DEBUG_EN_O,
   output logic PORT_B_BIT67_IO_O,
   output logic EXTENDED_ISA_EN_O,
   output logic [10:0] BOOT_BLOCK_WORDS_O,
   output logic STACK_ERROR_RESET_EN_O,
   output logic [1:0] CODE_PROTECT_BLOCK_O,
   output logic DATA_NVM_PROTECT_O,
   output logic BOOT_AREA_PROTECT_O
);
   import cfb_pkg::*;

   localparam int NREG = 8;

   logic [7:0] nv_mem [NREG];
   logic [7:0] shadow [NREG];
   logic [3:0] hit;

   // Bit 3 is the hit flag, bits 2:0 the storage index
   function automatic logic [3:0] idx_of(input logic [23:0] a);
      case (a)
         `CFB_OFS_OSC: idx_of = 4'h8;
         `CFB_OFS_BOR: idx_of = 4'h9;
         `CFB_OFS_WDT: idx_of = 4'ha;
         `CFB_OFS_PWM: idx_of = 4'hb;
         `CFB_OFS_MUX: idx_of = 4'hc;
         `CFB_OFS_DBG: idx_of = 4'hd;
         `CFB_OFS_CPL: idx_of = 4'he;
         `CFB_OFS_CPH: idx_of = 4'hf;
         default: idx_of = 4'h0;
      endcase
   endfunction

   function automatic logic [7:0] mask_of(input logic [2:0] i);
      case (i)
         3'h0: mask_of = `CFB_MSK_OSC;
         3'h1: mask_of = `CFB_MSK_BOR;
         3'h2: mask_of = `CFB_MSK_WDT;
         3'h3: mask_of = `CFB_MSK_PWM;
         3'h4: mask_of = `CFB_MSK_MUX;
         3'h5: mask_of = `CFB_MSK_DBG;
         3'h6: mask_of = `CFB_MSK_CPL;
         default: mask_of = `CFB_MSK_CPH;
      endcase
   endfunction

   function automatic logic [7:0] default_of(input logic [2:0] i);
      case (i)
         3'h0: default_of = `CFB_DEF_OSC;
         3'h1: default_of = `CFB_DEF_BOR;
         3'h2: default_of = `CFB_DEF_WDT;
         3'h3: default_of = `CFB_DEF_PWM;
         3'h4: default_of = `CFB_DEF_MUX;
         3'h5: default_of = `CFB_DEF_DBG;
         3'h6: default_of = `CFB_DEF_CPL;
         default: default_of = `CFB_DEF_CPH;
      endcase
   endfunction

   function automatic cfb_osc_dec_t osc_decode(input logic [3:0] f);
      cfb_osc_dec_t d;
      d = '{OSC_EXTERNAL_RC, 1'b1, 1'b0, 1'b0, 1'b0};
      case (f)
         4'h9: d = '{OSC_INTERNAL_BLOCK, 1'b1, 1'b0, 1'b1, 1'b0};
         4'h8: d = '{OSC_INTERNAL_BLOCK, 1'b0, 1'b1, 1'b1, 1'b0};
         4'h7: d = '{OSC_EXTERNAL_RC, 1'b0, 1'b1, 1'b0, 1'b0};
         4'h6: d = '{OSC_HIGH_SPEED_PLL, 1'b0, 1'b0, 1'b0, 1'b1};
         4'h5: d = '{OSC_EXTERNAL_CLOCK_INPUT, 1'b0, 1'b1, 1'b0,
                     1'b0};
         4'h4: d = '{OSC_EXTERNAL_CLOCK_INPUT, 1'b1, 1'b0, 1'b0,
                     1'b0};
         4'h2: d = '{OSC_HIGH_SPEED_CRYSTAL, 1'b0, 1'b0, 1'b0, 1'b0};
         4'h1: d = '{OSC_STANDARD_CRYSTAL, 1'b0, 1'b0, 1'b0, 1'b0};
         4'h0: d = '{OSC_LOW_POWER_CRYSTAL, 1'b0, 1'b0, 1'b0, 1'b0};
         // 11xx, 101x and 0011 keep the external RC default
         default: d = '{OSC_EXTERNAL_RC, 1'b1, 1'b0, 1'b0, 1'b0};
      endcase
      osc_decode = d;
   endfunction

   assign hit = idx_of(BUS_I.addr);

   // Nonvolatile storage: only power-on returns it to unprogrammed
   always_ff @(posedge CLK_I) begin
      if (POR_I) begin
         for (int i = 0; i < NREG; i++) begin
            nv_mem[i] <= default_of(3'(i));
         end
      end else if (CE_I && BUS_I.wr && hit[3]) begin
         // Protect bytes only lose bits outside program mode
         if (hit[2:1] == 2'b11 && !PROG_MODE_I) begin
            nv_mem[hit[2:0]] <= nv_mem[hit[2:0]] & BUS_I.wdata;
         end else begin
            nv_mem[hit[2:0]] <= BUS_I.wdata & mask_of(hit[2:0]);
         end
      end
   end

   // Read data valid for one enabled cycle, zero after other enabled cycles, held while CE_I is low
   always_ff @(posedge CLK_I) begin
      if (RST_I || POR_I) begin
         RD_DATA_O <= 8'h00;
      end else if (CE_I) begin
         if (BUS_I.rd && hit[3]) begin
            RD_DATA_O <= nv_mem[hit[2:0]] & mask_of(hit[2:0]);
         end else begin
            RD_DATA_O <= 8'h00;
         end
      end
   end

   // Decode sees only what was sampled at reset, so new writes take
   // effect at the next device reset and outputs never glitch between.
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         for (int i = 0; i < NREG; i++) begin
            shadow[i] <= nv_mem[i] & mask_of(3'(i));
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      cfb_osc_dec_t od;
      od = osc_decode(shadow[0][3:0]);
      if (CE_I) begin
         OSC_SOURCE_O <= od.src;
         CLOCK_OUT_PIN_O <= od.clock_out_pin;
         PORT_A_BIT6_IO_O <= od.port_a_bit6_io;
         PORT_A_BIT7_IO_O <= od.port_a_bit7_io;
         PLL_EN_O <= od.pll;
         OSC_SWITCHOVER_EN_O <= shadow[0][`CFB_B_SWITCHOVER];
         FAILSAFE_MONITOR_EN_O <= shadow[0][`CFB_B_FAILSAFE];
      end
   end

   // Brown-out tracks sleep and the software bit live
   always_ff @(posedge CLK_I) begin
      if (CE_I) begin
         case (shadow[1][2:1])
            2'b11: BROWNOUT_ACTIVE_O <= 1'b1;
            2'b10: BROWNOUT_ACTIVE_O <= !SLEEP_I;
            2'b01: BROWNOUT_ACTIVE_O <= SOFT_BROWNOUT_EN_I;
            default: BROWNOUT_ACTIVE_O <= 1'b0;
         endcase
         BROWNOUT_LEVEL_O <= shadow[1][4:3];
         POWERUP_TIMER_EN_O <= !shadow[1][`CFB_B_PWRT_N];
      end
   end

   always_ff @(posedge CLK_I) begin
      if (CE_I) begin
         WATCHDOG_RATIO_O <= 16'h0001 << shadow[2][4:1];
         WATCHDOG_RUN_O <= shadow[2][`CFB_B_WDT_EN]
                           || WATCHDOG_SOFT_EN_I;
         WATCHDOG_BASE_CYC_O <= 32'(WDT_BASE_CYC);
      end
   end

   // Logical PWM levels come in already merged with fault and override
   always_ff @(posedge CLK_I) begin
      logic odd_pol;
      logic even_pol;
      odd_pol = shadow[3][`CFB_B_ODD_POL];
      even_pol = shadow[3][`CFB_B_EVEN_POL];
      if (CE_I) begin
         ODD_PWM_POLARITY_O <= odd_pol;
         EVEN_PWM_POLARITY_O <= even_pol;
         for (int i = 0; i < 6; i++) begin
            PWM_PIN_O[i] <= PWM_LOGIC_I[i]
                            ^ ~((i % 2 == 1) ? odd_pol : even_pol);
         end
         PWM_OFF_AT_RESET_O <= shadow[3][`CFB_B_PWM_RST];
         PWM_OUTPUT_ENABLES_O <= shadow[3][`CFB_B_PWM_RST] ? 3'h0
                                 : `CFB_PWM_EN_ACTIVE;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (CE_I) begin
         EXTERNAL_RESET_EN_O <= shadow[4][`CFB_B_EXTERNAL_RESET_PIN_EN];
         PORT_A_BIT5_IN_EN_O <= !shadow[4][`CFB_B_EXTERNAL_RESET_PIN_EN];
         TIMER1_PIN_ON_A6_O <= shadow[4][`CFB_B_T1_MUX];
         FAULT_A_ON_A5_O <= shadow[4][`CFB_B_FLT_MUX];
      end
   end

   always_ff @(posedge CLK_I) begin
      if (CE_I) begin
         DEBUG_EN_O <= !shadow[5][`CFB_B_BKDBG];
         PORT_B_BIT67_IO_O <= shadow[5][`CFB_B_BKDBG];
         EXTENDED_ISA_EN_O <= shadow[5][`CFB_B_XISA];
         STACK_ERROR_RESET_EN_O <= shadow[5][`CFB_B_STK_RST];
         case (shadow[5][5:4])
            2'b00: BOOT_BLOCK_WORDS_O <= `CFB_BB_256;
            2'b01: BOOT_BLOCK_WORDS_O <= `CFB_BB_512;
            default: BOOT_BLOCK_WORDS_O <= LARGE_PART ? `CFB_BB_1K
                                           : `CFB_BB_512;
         endcase
      end
   end

   // Protection is active when the fuse reads zero
   always_ff @(posedge CLK_I) begin
      if (CE_I) begin
         CODE_PROTECT_BLOCK_O <= ~shadow[6][1:0];
         DATA_NVM_PROTECT_O <= !shadow[7][`CFB_B_CP_DATA];
         BOOT_AREA_PROTECT_O <= !shadow[7][`CFB_B_CP_BOOT];
      end
   end

endmodule

/* File: cfb_chk.sv */
// Checker for the fuse bank, watching the top module's ports only.
// Assumes one clock domain and synchronous resets RST_I and POR_I.
`timescale 1ns/1ps
`include "cfb_cfg.svh"
module cfb_chk #(
   parameter int WDT_BASE_CYC = 16
) (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic POR_I,
   input wire logic CE_I,
   input wire cfb_pkg::cfb_bus_t BUS_I,
   input wire logic WATCHDOG_SOFT_EN_I,
   input wire logic [5:0] PWM_LOGIC_I,
   input wire logic [7:0] RD_DATA_O,
   input wire cfb_pkg::cfb_osc_src_t OSC_SOURCE_O,
   input wire logic PORT_A_BIT7_IO_O,
   input wire logic PLL_EN_O,
   input wire logic WATCHDOG_RUN_O,
   input wire logic [15:0] WATCHDOG_RATIO_O,
   input wire logic [31:0] WATCHDOG_BASE_CYC_O,
   input wire logic ODD_PWM_POLARITY_O,
   input wire logic EVEN_PWM_POLARITY_O,
   input wire logic [5:0] PWM_PIN_O,
   input wire logic EXTERNAL_RESET_EN_O,
   input wire logic PORT_A_BIT5_IN_EN_O,
   input wire logic [10:0] BOOT_BLOCK_WORDS_O
);
   import cfb_pkg::*;
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RST_I || POR_I);
   logic [5:0] pol;
   assign pol = {3{ODD_PWM_POLARITY_O, EVEN_PWM_POLARITY_O}};
   sequence s_rd(a);
      BUS_I.rd && CE_I && BUS_I.addr == a;
   endsequence
   // Two quiet edges after reset, so the decode has landed
   sequence s_settled;
      !$past(RST_I) && !$past(RST_I, 2) && $past(CE_I);
   endsequence
   property p_rd_idle;
      $past(CE_I) && !$past(BUS_I.rd) |-> RD_DATA_O == 8'h00;
   endproperty
   property p_osc_unimpl;
      s_rd(`CFB_OFS_OSC) |=> (RD_DATA_O & ~`CFB_MSK_OSC) == 8'h00;
   endproperty
   property p_unmapped;
      s_rd(24'h300007) |=> RD_DATA_O == 8'h00;
   endproperty
   property p_hold;
      s_settled |-> $stable({OSC_SOURCE_O, WATCHDOG_RATIO_O,
         BOOT_BLOCK_WORDS_O, EXTERNAL_RESET_EN_O});
   endproperty
   property p_pll;
      PLL_EN_O |-> OSC_SOURCE_O == OSC_HIGH_SPEED_PLL;
   endproperty
   property p_bit7;
      PORT_A_BIT7_IO_O |-> OSC_SOURCE_O == OSC_INTERNAL_BLOCK;
   endproperty
   property p_wdt_soft;
      s_settled ##0 $past(WATCHDOG_SOFT_EN_I) |-> WATCHDOG_RUN_O;
   endproperty
   property p_pwm;
      s_settled |-> PWM_PIN_O == ($past(PWM_LOGIC_I) ^ ~pol);
   endproperty
   property p_external_reset_pin;
      EXTERNAL_RESET_EN_O != PORT_A_BIT5_IN_EN_O;
   endproperty
   property p_base;
      WATCHDOG_BASE_CYC_O == WDT_BASE_CYC;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data not zero outside a read");
   a_osc_unimpl: assert property (p_osc_unimpl)
      else $error("unused oscillator bits read non-zero");
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   a_hold: assert property (p_hold)
      else $error("decoded outputs moved without reset");
   a_pll: assert property (p_pll)
      else $error("pll on outside pll crystal mode");
   a_bit7: assert property (p_bit7)
      else $error("port a bit7 freed outside internal block");
   a_wdt_soft: assert property (p_wdt_soft)
      else $error("soft watchdog enable ignored");
   a_pwm: assert property (p_pwm)
      else $error("pwm pin polarity wrong");
   a_external_reset_pin: assert property (p_external_reset_pin)
      else $error("reset pin and port input not exclusive");
   a_base: assert property (p_base)
      else $error("watchdog base period wrong");
endmodule
bind cfb_top cfb_chk #(.WDT_BASE_CYC(WDT_BASE_CYC)) chk_u (.CLK_I, .RST_I,
   .POR_I, .CE_I, .BUS_I, .WATCHDOG_SOFT_EN_I, .PWM_LOGIC_I, .RD_DATA_O,
   .OSC_SOURCE_O, .PORT_A_BIT7_IO_O, .PLL_EN_O, .WATCHDOG_RUN_O,
   .WATCHDOG_RATIO_O, .WATCHDOG_BASE_CYC_O, .ODD_PWM_POLARITY_O,
   .EVEN_PWM_POLARITY_O, .PWM_PIN_O, .EXTERNAL_RESET_EN_O,
   .PORT_A_BIT5_IN_EN_O, .BOOT_BLOCK_WORDS_O);

/* File: tb.sv */
// Self-checking bench for the fuse bank top.
// Assumes the one-cycle strobe register port and sync resets.
`timescale 1ns/1ps
`include "cfb_cfg.svh"
module tb;
   import cfb_pkg::*;
   localparam int BASE = 16;
   logic CLK_I = 0, RST_I = 1, POR_I = 1, CE_I = 1, PROG_MODE_I = 0;
   logic SLEEP_I = 0, SOFT_BROWNOUT_EN_I = 0, WATCHDOG_SOFT_EN_I = 0;
   logic [5:0] PWM_LOGIC_I = '0;
   cfb_bus_t BUS_I = '0;
   cfb_osc_src_t OSC_SOURCE_O;
   logic CLOCK_OUT_PIN_O, PORT_A_BIT6_IO_O, PORT_A_BIT7_IO_O, PLL_EN_O;
   logic OSC_SWITCHOVER_EN_O, FAILSAFE_MONITOR_EN_O, BROWNOUT_ACTIVE_O;
   logic POWERUP_TIMER_EN_O, WATCHDOG_RUN_O, ODD_PWM_POLARITY_O;
   logic EVEN_PWM_POLARITY_O, PWM_OFF_AT_RESET_O, EXTERNAL_RESET_EN_O;
   logic PORT_A_BIT5_IN_EN_O, TIMER1_PIN_ON_A6_O, FAULT_A_ON_A5_O;
   logic DEBUG_EN_O, PORT_B_BIT67_IO_O, EXTENDED_ISA_EN_O;
   logic STACK_ERROR_RESET_EN_O, DATA_NVM_PROTECT_O, BOOT_AREA_PROTECT_O;
   logic [1:0] BROWNOUT_LEVEL_O, CODE_PROTECT_BLOCK_O;
   logic [2:0] PWM_OUTPUT_ENABLES_O;
   logic [5:0] PWM_PIN_O;
   logic [7:0] RD_DATA_O;
   logic [10:0] BOOT_BLOCK_WORDS_O;
   logic [15:0] WATCHDOG_RATIO_O;
   logic [31:0] WATCHDOG_BASE_CYC_O;
   int mismatches = 0;
   int cmp_count = 0;
   logic [23:0] ofs [8] = '{`CFB_OFS_OSC, `CFB_OFS_BOR, `CFB_OFS_WDT,
      `CFB_OFS_PWM, `CFB_OFS_MUX, `CFB_OFS_DBG, `CFB_OFS_CPL, `CFB_OFS_CPH};
   logic [7:0] dfl [8] = '{`CFB_DEF_OSC, `CFB_DEF_BOR, `CFB_DEF_WDT,
      `CFB_DEF_PWM, `CFB_DEF_MUX, `CFB_DEF_DBG, `CFB_DEF_CPL, `CFB_DEF_CPH};
   logic [6:0] e, m;
   cfb_top #(.WDT_BASE_CYC(BASE)) dut_u (.*);
   always #12.5 CLK_I = ~CLK_I;
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task stop_test;
      $display("mismatches %0d compares %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Leaves the strobe up; the next task call or the caller lowers it
   task wr(input logic [23:0] a, input logic [7:0] d);
      @(posedge CLK_I);
      BUS_I <= '{a, d, 1'b1, 1'b0};
   endtask
   task rdc(input logic [23:0] a, input logic [7:0] x);
      @(posedge CLK_I);
      BUS_I <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge CLK_I);
      BUS_I <= '0;
      #1 chk(RD_DATA_O, x);
   endtask
   // Storage survives; only the shadow reloads
   task rst_dev;
      @(posedge CLK_I);
      BUS_I <= '0;
      RST_I <= 1'b1;
      repeat (2) @(posedge CLK_I);
      RST_I <= 1'b0;
      repeat (3) @(posedge CLK_I);
      #1;
   endtask
   initial begin
      repeat (100000) @(posedge CLK_I);
      $display("[ERR] %0t timeout", $time);
      mismatches++;
      stop_test;
   end
   initial begin
      repeat (4) @(posedge CLK_I);
      POR_I <= 1'b0;
      @(posedge CLK_I);
      RST_I <= 1'b0;
      repeat (3) @(posedge CLK_I);
      #1;
      for (int i = 0; i < 8; i++) rdc(ofs[i], dfl[i]);
      rdc(24'h300007, 8'h00);
      chk({WATCHDOG_RATIO_O, WATCHDOG_RUN_O}, {16'h8000, 1'b1});
      chk(WATCHDOG_BASE_CYC_O, BASE);
      chk({POWERUP_TIMER_EN_O, EXTENDED_ISA_EN_O}, 2'b00);
      $display("test defaults done");
      for (int c = 0; c < 16; c++) begin
         wr(`CFB_OFS_OSC, {c[1:0], 2'b11, c[3:0]});
         rdc(`CFB_OFS_OSC, {c[1:0], 2'b00, c[3:0]});
         rst_dev;
         chk({OSC_SWITCHOVER_EN_O, FAILSAFE_MONITOR_EN_O}, c[1:0]);
         m = 7'h7f;
         casez (c[3:0])
            4'b11??, 4'b101?, 4'b0011: e = {OSC_EXTERNAL_RC, 4'b1000};
            4'b1001: e = {OSC_INTERNAL_BLOCK, 4'b1010};
            4'b1000: e = {OSC_INTERNAL_BLOCK, 4'b0110};
            4'b0111: e = {OSC_EXTERNAL_RC, 4'b0100};
            4'b0101: e = {OSC_EXTERNAL_CLOCK_INPUT, 4'b0100};
            4'b0100: e = {OSC_EXTERNAL_CLOCK_INPUT, 4'b1000};
            4'b0110: begin
               e = {OSC_HIGH_SPEED_PLL, 4'b0001};
               m = 7'h7b;
            end
            default: begin
               e = {c[2:0], 4'b0000};
               m = 7'h7b;
            end
         endcase
         chk(m & {OSC_SOURCE_O, CLOCK_OUT_PIN_O, PORT_A_BIT6_IO_O,
            PORT_A_BIT7_IO_O, PLL_EN_O}, m & e);
      end
      $display("test oscillator done");
      for (int i = 0; i < 16; i++) begin
         wr(`CFB_OFS_BOR, {3'b000, i[3:0], ~i[2]});
         wr(`CFB_OFS_WDT, {3'b000, i[3:0], i[1]});
         rst_dev;
         chk({BROWNOUT_LEVEL_O, POWERUP_TIMER_EN_O},
            {i[3:2], i[2]});
         chk(WATCHDOG_RATIO_O, 1 << i);
         for (int j = 0; j < 4; j++) begin
            @(posedge CLK_I);
            SLEEP_I <= j[1];
            SOFT_BROWNOUT_EN_I <= j[0];
            WATCHDOG_SOFT_EN_I <= j[0];
            repeat (2) @(posedge CLK_I);
            #1 chk(BROWNOUT_ACTIVE_O, i[1:0] == 3 || (i[1:0] == 2 && !j[1])
               || (i[1:0] == 1 && j[0]));
            chk(WATCHDOG_RUN_O, i[1] | j[0]);
         end
      end
      $display("test power watchdog done");
      for (int i = 0; i < 16; i++) begin
         wr(`CFB_OFS_PWM, {4'h0, i[1:0], i[2], 1'b0});
         wr(`CFB_OFS_MUX, {i[3], 3'b000, i[2], 2'b00, i[0]});
         wr(`CFB_OFS_DBG, {i[3:0], 3'b000, i[1]});
         rst_dev;
         PWM_LOGIC_I <= {i[1:0], i[3:0]};
         repeat (2) @(posedge CLK_I);
         #1 chk({ODD_PWM_POLARITY_O, EVEN_PWM_POLARITY_O}, i[1:0]);
         chk({PWM_OFF_AT_RESET_O, PWM_OUTPUT_ENABLES_O},
            i[2] ? 4'h8 : 4'h4);
         chk(PWM_PIN_O, 6'({i[1:0], i[3:0]} ^ ~{3{i[1:0]}}));
         chk({EXTERNAL_RESET_EN_O, PORT_A_BIT5_IN_EN_O}, {i[3], ~i[3]});
         chk({TIMER1_PIN_ON_A6_O, FAULT_A_ON_A5_O}, {i[2], i[0]});
         chk({DEBUG_EN_O, PORT_B_BIT67_IO_O}, {~i[3], i[3]});
         chk(EXTENDED_ISA_EN_O, i[2]);
         chk(BOOT_BLOCK_WORDS_O, i[1:0] == 0 ? 256 :
            (i[1:0] == 1 ? 512 : 1024));
         chk(STACK_ERROR_RESET_EN_O, i[1]);
      end
      $display("test pwm mux debug done");
      wr(`CFB_OFS_CPL, 8'h02);
      rdc(`CFB_OFS_CPL, 8'h02);
      wr(`CFB_OFS_CPL, 8'hff);
      rdc(`CFB_OFS_CPL, 8'h02);
      wr(`CFB_OFS_CPH, 8'h40);
      wr(`CFB_OFS_CPH, 8'hff);
      rdc(`CFB_OFS_CPH, 8'h40);
      rst_dev;
      chk({CODE_PROTECT_BLOCK_O, DATA_NVM_PROTECT_O,
         BOOT_AREA_PROTECT_O}, 4'b0110);
      PROG_MODE_I <= 1'b1;
      wr(`CFB_OFS_CPH, 8'hff);
      rdc(`CFB_OFS_CPH, 8'hc0);
      $display("test protect done");
      // Write while frozen must be dropped
      @(posedge CLK_I);
      CE_I <= 1'b0;
      wr(`CFB_OFS_WDT, 8'h00);
      @(posedge CLK_I);
      BUS_I <= '0;
      CE_I <= 1'b1;
      rdc(`CFB_OFS_WDT, 8'h1f);
      $display("test clock enable done");
      stop_test;
   end
endmodule
